// ==== pbcd_decode.sv ====
// Purpose: decodes host control pins of a 16-bit pseudo-static ram into operating states
// Assumes: host drives every control pin to a valid level; pins are synchronous to clk
// Notes:   burst latency and sequencing are outside this block; the bus clock is a
//          sampled input, its rising edge found against clk
`timescale 1ns/1ns
module pbcd_decode #(
    parameter int DATA_W = pbcd_pkg::DATA_W,
    parameter int ADDR_W = pbcd_pkg::ADDR_W
) (
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              chip_sel_n,
    input  wire logic              mode_reg_set_n,
    input  wire logic              out_en_n,
    input  wire logic              write_n,
    input  wire logic              low_byte_lane_n,
    input  wire logic              high_byte_lane_n,
    input  wire logic              addr_valid_n,
    input  wire logic              bus_clk,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              pending_in,
    input  wire logic [DATA_W-1:0] mem_rdata,
    input  wire logic [DATA_W-1:0] dq_in,
    output logic      [DATA_W-1:0] dq_out,
    output logic      [1:0]        dq_oe_n,
    output logic                   data_pending_n_out,
    output logic                   data_pending_n_oe_n,
    output logic      [1:0]        op_mode_field,
    output logic      [3:0]        bus_state,
    output logic                   array_subset_refresh,
    output logic                   wr_strobe,
    output logic      [1:0]        wr_lane,
    output logic      [DATA_W-1:0] wr_data,
    output logic                   burst_start
);

    localparam int HALF = DATA_W / 2;

    if (DATA_W != pbcd_pkg::DATA_W || ADDR_W <= pbcd_pkg::MODE_MSB) begin : g_bad_size
        $error("pbcd_decode: unsupported DATA_W or ADDR_W");
    end

    logic [1:0]            op_mode_q;
    pbcd_pkg::pbcd_state_t state_q;
    pbcd_pkg::pbcd_state_t state_d;
    logic                  bus_clk_q;
    logic                  clk_rise;
    logic                  sync_mode;
    logic                  any_lane;
    logic                  mode_set;
    logic [DATA_W-1:0]     dq_out_q;
    logic [1:0]            dq_oe_n_q;
    logic                  pend_q;
    logic                  pend_oe_n_q;
    logic                  wr_strobe_q;
    logic [1:0]            wr_lane_q;
    logic [DATA_W-1:0]     wr_data_q;
    logic                  burst_start_q;
    logic                  refresh_q;

    // active-low lanes to an active-high pair {high, low}
    function automatic logic [1:0] lanes(input logic lo_n, input logic hi_n);
        lanes = {~hi_n, ~lo_n};
    endfunction

    // the unused fourth code is not a clocked mode and decodes to idle whenever selected and not a mode set
    assign sync_mode = (op_mode_q == pbcd_pkg::MODE_SRD_AWR)
                       || (op_mode_q == pbcd_pkg::MODE_SRD_SWR);
    assign any_lane  = |lanes(low_byte_lane_n, high_byte_lane_n);
    // only host-driven pins decide the state; pending_in is never read here
    assign mode_set  = !chip_sel_n && !mode_reg_set_n && out_en_n && !write_n
                       && !low_byte_lane_n && !high_byte_lane_n;
    assign clk_rise  = bus_clk && !bus_clk_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_clk_q <= 1'b0;
        end else begin
            bus_clk_q <= bus_clk;
        end
    end

    always_comb begin
        state_d = pbcd_pkg::PBCD_ST_IDLE;
        if (chip_sel_n) begin
            state_d = mode_reg_set_n ? pbcd_pkg::PBCD_ST_STANDBY
                                     : pbcd_pkg::PBCD_ST_REFRESH;
        end else if (mode_set) begin
            state_d = pbcd_pkg::PBCD_ST_MODE_SET;
        end else if (!mode_reg_set_n) begin
            state_d = pbcd_pkg::PBCD_ST_IDLE;
        end else begin
            // a clocked command needs no byte lane; plain transfers do
            case (op_mode_q)
                pbcd_pkg::MODE_ASYNC: begin
                    // clock and addr_valid_n play no part here
                    if (!any_lane) state_d = pbcd_pkg::PBCD_ST_IDLE;
                    else if (!write_n) state_d = pbcd_pkg::PBCD_ST_WRITE;
                    else if (!out_en_n) state_d = pbcd_pkg::PBCD_ST_READ;
                end
                pbcd_pkg::MODE_SRD_AWR: begin
                    if (!write_n) begin
                        if (any_lane) state_d = pbcd_pkg::PBCD_ST_WRITE;
                    end else if (state_q == pbcd_pkg::PBCD_ST_BRD
                                 || (clk_rise && !addr_valid_n)) begin
                        state_d = pbcd_pkg::PBCD_ST_BRD;
                    end
                end
                pbcd_pkg::MODE_SRD_SWR: begin
                    if (clk_rise && !addr_valid_n) begin
                        state_d = write_n ? pbcd_pkg::PBCD_ST_BRD
                                          : pbcd_pkg::PBCD_ST_BWR;
                    end else if (state_q == pbcd_pkg::PBCD_ST_BRD
                                 || state_q == pbcd_pkg::PBCD_ST_BWR) begin
                        state_d = state_q;
                    end
                end
                default: state_d = pbcd_pkg::PBCD_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= pbcd_pkg::PBCD_ST_STANDBY;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            op_mode_q <= pbcd_pkg::MODE_RESET;
        end else if (mode_set) begin
            op_mode_q <= addr[pbcd_pkg::MODE_MSB:pbcd_pkg::MODE_LSB];
        end
    end

    // start pulse only on a sampled clock edge while selected and in a clocked mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            burst_start_q <= 1'b0;
        end else begin
            burst_start_q <= sync_mode && !chip_sel_n && mode_reg_set_n && clk_rise
                             && !addr_valid_n
                             && (!write_n ? op_mode_q == pbcd_pkg::MODE_SRD_SWR : 1'b1);
        end
    end

    // read data drive, per byte lane
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            dq_oe_n_q <= pbcd_pkg::LANES_OFF_N;
            dq_out_q  <= '0;
        end else begin
            dq_out_q <= mem_rdata;
            if (state_d == pbcd_pkg::PBCD_ST_READ || state_d == pbcd_pkg::PBCD_ST_BRD) begin
                dq_oe_n_q <= out_en_n ? pbcd_pkg::LANES_OFF_N
                                      : ~lanes(low_byte_lane_n, high_byte_lane_n);
            end else begin
                dq_oe_n_q <= pbcd_pkg::LANES_OFF_N;
            end
        end
    end

    // write capture, masked per lane
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_strobe_q <= 1'b0;
            wr_lane_q   <= 2'h0;
            wr_data_q   <= '0;
        end else begin
            wr_strobe_q <= 1'b0;
            wr_lane_q   <= 2'h0;
            if (state_d == pbcd_pkg::PBCD_ST_WRITE
                || (state_d == pbcd_pkg::PBCD_ST_BWR && state_q == pbcd_pkg::PBCD_ST_BWR
                    && clk_rise && addr_valid_n)) begin
                wr_strobe_q <= 1'b1;
                wr_lane_q   <= lanes(low_byte_lane_n, high_byte_lane_n);
                wr_data_q[HALF-1:0]      <= low_byte_lane_n ? wr_data_q[HALF-1:0]
                                                            : dq_in[HALF-1:0];
                wr_data_q[DATA_W-1:HALF] <= high_byte_lane_n ? wr_data_q[DATA_W-1:HALF]
                                                             : dq_in[DATA_W-1:HALF];
            end
        end
    end

    // refresh flag registered so the pin comes from a flip-flop
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            refresh_q <= 1'b0;
        end else begin
            refresh_q <= (state_d == pbcd_pkg::PBCD_ST_REFRESH);
        end
    end

    // wait indicator: released in async mode, driven from the core in clocked modes while chip_sel_n is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_q      <= 1'b1;
            pend_oe_n_q <= 1'b1;
        end else begin
            pend_q      <= ~pending_in;
            pend_oe_n_q <= !(sync_mode && !chip_sel_n);
        end
    end

    assign dq_out               = dq_out_q;
    assign dq_oe_n              = dq_oe_n_q;
    assign data_pending_n_out   = pend_q;
    assign data_pending_n_oe_n  = pend_oe_n_q;
    assign op_mode_field        = op_mode_q;
    assign bus_state            = state_q;
    assign array_subset_refresh = refresh_q;
    assign wr_strobe            = wr_strobe_q;
    assign wr_lane              = wr_lane_q;
    assign wr_data              = wr_data_q;
    assign burst_start          = burst_start_q;

endmodule

// ==== pbcd_decode_monitor.sv ====
// Purpose: port assertions for the bus decoder
// Assumes: mode code 3 is never written
// Notes: bound to every decoder instance
`timescale 1ns/1ns
module pbcd_decode_monitor #(
    parameter int ADDR_W = 23
) (
    input wire logic              clk,
    input wire logic              arst_n,
    input wire logic              chip_sel_n,
    input wire logic              mode_reg_set_n,
    input wire logic              out_en_n,
    input wire logic              write_n,
    input wire logic              low_byte_lane_n,
    input wire logic              high_byte_lane_n,
    input wire logic              addr_valid_n,
    input wire logic              bus_clk,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [1:0]        dq_oe_n,
    input wire logic [1:0]        op_mode_field,
    input wire logic [1:0]        wr_lane,
    input wire logic [3:0]        bus_state,
    input wire logic              data_pending_n_oe_n,
    input wire logic              array_subset_refresh,
    input wire logic              wr_strobe,
    input wire logic              burst_start
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    wire logic [1:0] ln = {high_byte_lane_n, low_byte_lane_n};
    wire logic [1:0] am = addr[15:14];
    wire logic rd = !chip_sel_n && mode_reg_set_n && !out_en_n && write_n;
    wire logic ms = !chip_sel_n && !mode_reg_set_n && out_en_n && !write_n && !addr_valid_n;
    wire logic bs = !chip_sel_n && mode_reg_set_n && !addr_valid_n && bus_clk;
    property p_refresh; chip_sel_n && !mode_reg_set_n |=> array_subset_refresh; endproperty
    a_refresh: assert property (p_refresh) else $error("refresh");
    property p_pend_hz; !op_mode_field && !$past(op_mode_field) |-> data_pending_n_oe_n;
    endproperty
    a_pend_hz: assert property (p_pend_hz) else $error("wait pin");
    property p_mode_set; ms && !ln |=> bus_state == 4'h5 && op_mode_field == $past(am); endproperty
    a_mode_set: assert property (p_mode_set) else $error("mode set");
    property p_desel; chip_sel_n |=> dq_oe_n == 2'h3; endproperty
    a_desel: assert property (p_desel) else $error("deselect");
    property p_burst_cause; burst_start |-> $past(bs) && $past(op_mode_field) != 2'h0; endproperty
    a_burst_cause: assert property (p_burst_cause) else $error("burst cause");
    property p_wr_lane; wr_strobe |-> wr_lane == ~$past(ln); endproperty
    a_wr_lane: assert property (p_wr_lane) else $error("write lanes");
    property p_read_lane; rd && op_mode_field == 2'h0 |=> dq_oe_n == $past(ln); endproperty
    a_read_lane: assert property (p_read_lane) else $error("read lanes");
    property p_burst_wr; op_mode_field == 2'h2 && bs && !write_n && !$past(bus_clk)
        |=> burst_start && bus_state == 4'h7; endproperty
    a_burst_wr: assert property (p_burst_wr) else $error("burst write");
    c_burst_wr: cover property (burst_start && bus_state == 4'h7);
    c_refresh: cover property (array_subset_refresh);
    c_mode: cover property (bus_state == 4'h5 ##1 op_mode_field == 2'h2);
endmodule
bind pbcd_decode pbcd_decode_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

// ==== pbcd_host.sv ====
// Purpose: host controller model on the ram pins
// Assumes: put is called once per clk edge at most
// Notes: pins start in standby with the bus clock still
`timescale 1ns/1ns
module pbcd_host (
    input  wire logic                   clk,
    output logic                        chip_sel_n,
    output logic                        mode_reg_set_n,
    output logic                        out_en_n,
    output logic                        write_n,
    output logic                        low_byte_lane_n,
    output logic                        high_byte_lane_n,
    output logic                        addr_valid_n,
    output logic                        bus_clk,
    output logic [pbcd_pkg::ADDR_W-1:0] addr,
    output logic [pbcd_pkg::DATA_W-1:0] hdata
);
    logic [7:0] pins = 8'hFE;
    // no wait pin input: only control pins define the operation
    assign {chip_sel_n, mode_reg_set_n, out_en_n, write_n, low_byte_lane_n, high_byte_lane_n,
            addr_valid_n, bus_clk} = pins;
    initial begin
        addr = 23'h0;
        hdata = 16'h0;
    end
    task automatic put(input logic [7:0] c, input logic [22:0] a);
        @(posedge clk);
        pins <= c;
        addr <= a;
        hdata <= (c[5] && !c[7]) ? a[15:0] : 16'($urandom);
    endtask
endmodule

// ==== pbcd_pkg.sv ====
// Purpose: constants and types for the pseudo-static ram bus command decoder
// Assumes: all bus pins sampled synchronously to clk
// Notes:   mode select codes follow the two-bit field carried on address bits 15..14
package pbcd_pkg;

    localparam int         DATA_W        = 16;
    localparam int         ADDR_W        = 23;
    localparam int         MODE_LSB      = 14;
    localparam int         MODE_MSB      = 15;
    localparam logic [1:0] MODE_ASYNC    = 2'h0;
    localparam logic [1:0] MODE_SRD_AWR  = 2'h1;
    localparam logic [1:0] MODE_SRD_SWR  = 2'h2;
    localparam logic [1:0] MODE_RESET    = 2'h0;
    localparam logic [1:0] LANES_OFF_N   = 2'h3;

    typedef enum logic [3:0] {
        PBCD_ST_STANDBY  = 4'h0,
        PBCD_ST_REFRESH  = 4'h1,
        PBCD_ST_IDLE     = 4'h2,
        PBCD_ST_READ     = 4'h3,
        PBCD_ST_WRITE    = 4'h4,
        PBCD_ST_MODE_SET = 4'h5,
        PBCD_ST_BRD      = 4'h6,
        PBCD_ST_BWR      = 4'h7
    } pbcd_state_t;

endpackage

// ==== test_psram_bus_command_decode.sv ====
// Purpose: self-checking bench for the bus decoder
// Assumes: every host op is held for two clk edges
// Notes: write results are matched in order through a queue
`timescale 1ns/1ns
module test_psram_bus_command_decode;
    logic clk = 1'b0, arst_n = 1'b0, pending_in = 1'b0;
    logic chip_sel_n, mode_reg_set_n, out_en_n, write_n, low_byte_lane_n, high_byte_lane_n;
    logic addr_valid_n, bus_clk, data_pending_n_out, data_pending_n_oe_n, array_subset_refresh;
    logic wr_strobe, burst_start;
    logic [22:0] addr;
    logic [15:0] mem_rdata = 16'h0, dq_in, dq_out, hdata, wr_data, wd = 16'h0;
    logic [1:0] dq_oe_n, op_mode_field, wr_lane, l;
    logic [3:0] bus_state;
    wire logic [7:0] rd_obs = {dq_oe_n, bus_state, data_pending_n_oe_n, burst_start};
    wire logic [1:0] pend_obs = {data_pending_n_oe_n, data_pending_n_out};
    logic [17:0] exp_q[$];
    int bad_count = 0, checked = 0;
    always #5 clk = ~clk;
    assign dq_in = {dq_oe_n[1] ? hdata[15:8] : dq_out[15:8], dq_oe_n[0] ? hdata[7:0] : dq_out[7:0]};
    pbcd_host host (.*);
    pbcd_decode dut (.*);
    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic op(input logic [7:0] c, input logic [22:0] a = 23'h0);
        host.put(c, a);
        pending_in <= 1'($urandom);
        mem_rdata <= 16'($urandom);
        @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] c, input int n);
        logic [15:0] d;
        l = 2'($urandom_range(2));
        d = 16'($urandom);
        if (!l[1]) wd[7:0] = d[7:0];
        if (!l[0]) wd[15:8] = d[15:8];
        repeat (n) exp_q.push_back({~l[0], ~l[1], wd});
        op(c | {4'h0, l, 2'h0}, {7'h0, d});
        if (c[0]) op((c | {4'h0, l, 2'h0}) & 8'hFE, {7'h0, d});
    endtask
    // outputs are looked at mid-cycle, where they have settled
    always @(negedge clk) if (arst_n && wr_strobe === 1'b1) begin
        chk("queued", 18'h1, 18'(exp_q.size() != 0));
        if (exp_q.size() != 0) chk("write", exp_q.pop_front(), {wr_lane, wr_data});
    end
    initial begin
        void'($urandom(32'h0C95));
        repeat (3) @(posedge clk);
        chk("reset", 18'h7, {bus_state, op_mode_field, dq_oe_n, data_pending_n_oe_n});
        arst_n <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            op(8'h20, {7'h0, 2'(m), 14'(m * 5)});
            chk("mode", {2'(m), 4'h5}, {op_mode_field, bus_state});
            case (m)
                0: begin
                    wr(8'h61, 4);
                    for (int k = 0; k < 3; k++) begin
                        l = 2'(k);
                        op(8'h51 | {4'h0, l, 2'h0});
                        chk("read", {l[0], l[1], 4'h3, 2'h2}, rd_obs);
                        chk("read data", 18'(mem_rdata), 18'(dq_out));
                    end
                end
                1: begin
                    wr(8'h62, 2);
                    op(8'hFC);
                    op(8'hFD);
                    chk("deselect", 18'h60, {dq_oe_n, bus_state, burst_start});
                    op(8'h72);
                    op(8'h73);
                    chk("no address", 18'h0, burst_start);
                    op(8'h70);
                    op(8'h71);
                    chk("burst read", 18'hD, {bus_state, burst_start});
                    chk("wait pin", 18'(!pending_in), pend_obs);
                end
                default: begin
                    op(8'h60);
                    op(8'h61);
                    chk("burst write", 18'hF, {bus_state, burst_start});
                    op(8'h72);
                    repeat (3) wr(8'h73, 1);
                end
            endcase
        end
        op(8'hBE);
        repeat (50) @(posedge clk);
        #1;
        chk("refresh", 18'h3, {bus_state, array_subset_refresh});
        op(8'hFE);
        chk("standby", 18'h0, {bus_state, array_subset_refresh});
        chk("queue", 18'h0, 18'(exp_q.size()));
        test_done();
    end
    initial begin
        #20000;
        bad_count++;
        test_done();
    end
endmodule
